// *** logic/framed_serial_pkg.sv ***
// Overview of operation
// - Loopback routes receive sync, data internally; clock only when on-chip
// - Format bit picks 16-bit or 8-bit words
// - Byte mode sends low byte, receives low byte
// - Burst mode needs a sync per word
// - Continuous mode needs one sync; later syncs act
// - Sync source bit drives transmit sync as output
// - Clock source bit drives quarter-rate transmit clock
// - Receive clock and sync pins always inputs
// - Separate active-low transmitter and receiver resets
// - Transmit clock undriven when all three bits low
// - Bits 8 and 9 show clock pin levels
// - Receive ready rises on copy, raises interrupt
// - Transmit ready rises on copy, raises interrupt
// - Underflow flag low on empty or reset
// - Underflow halts transmitter, data output undriven
// - Overrun sets when data unread and shifter full
// - Overrun halts receiver, keeps shifter contents
// - Overrun clears on read or reset
// - Both halt bits low stop clocks immediately
// - Graceful stop finishes word; free-run keeps running
`default_nettype none

package framed_serial_pkg;

	// ****************************************************************
	// Register map, byte addresses on the bus.
	// ****************************************************************
	localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
	localparam logic [3:0]  TX_DATA_OFFSET  = 4'h4;
	localparam logic [3:0]  RX_DATA_OFFSET  = 4'h8;

	// ****************************************************************
	// Control word fields.
	// ****************************************************************
	localparam int          BIT_LOOPBACK    = 1;
	localparam int          BIT_FORMAT      = 2;
	localparam int          BIT_FRAME_MODE  = 3;
	localparam int          BIT_CLOCK_SRC   = 4;
	localparam int          BIT_SYNC_SRC    = 5;
	localparam int          BIT_TX_RESET_N  = 6;
	localparam int          BIT_RX_RESET_N  = 7;
	localparam int          BIT_RX_CLK_LVL  = 8;
	localparam int          BIT_TX_CLK_LVL  = 9;
	localparam int          BIT_RX_READY    = 10;
	localparam int          BIT_TX_READY    = 11;
	localparam int          BIT_UNDERFLOW_N = 12;
	localparam int          BIT_OVERRUN     = 13;
	localparam int          BIT_SOFT_STOP   = 14;
	localparam int          BIT_FREE_RUN    = 15;
	localparam logic [15:0] CTRL_WRITE_MASK = 16'hc0fe;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam logic [15:0] DATA_RESET      = 16'h0000;
	localparam logic        TX_READY_RESET  = 1'b1;

	// ****************************************************************
	// Word lengths and the on-chip clock divider.
	// ****************************************************************
	localparam logic [4:0]  WORD_BITS_FULL  = 5'd16;
	localparam logic [4:0]  WORD_BITS_BYTE  = 5'd8;
	localparam int          TX_CLK_DIVIDE   = 4;
	localparam int          DIV_W           = $clog2(TX_CLK_DIVIDE);

	// ****************************************************************
	// Pin input slots in the synchroniser vector.
	// ****************************************************************
	localparam int          PIN_TX_CLK      = 0;
	localparam int          PIN_TX_SYNC     = 1;
	localparam int          PIN_RX_CLK      = 2;
	localparam int          PIN_RX_SYNC     = 3;
	localparam int          PIN_DATA        = 4;
	localparam int          PIN_COUNT       = 5;

	// ****************************************************************
	// Sequencer states.
	// ****************************************************************
	typedef enum logic [2:0] {
		TX_IDLE,
		TX_WAIT_SYNC,
		TX_GEN_SYNC,
		TX_ARMED,
		TX_SHIFT
	} tx_state_t;

	typedef enum logic {
		RX_IDLE,
		RX_SHIFT
	} rx_state_t;

endpackage

`default_nettype wire

// *** logic/framed_serial_port.sv ***
`timescale 1ns/1ps
`default_nettype none

module framed_serial_port
	import framed_serial_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Register bus.
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Transmit clock pin.
	input  wire logic        transmit_serial_clock_in,
	output logic             transmit_serial_clock_out,
	output logic             transmit_serial_clock_oe,
	// Transmit frame sync pin.
	input  wire logic        transmit_frame_sync_in,
	output logic             transmit_frame_sync_out,
	output logic             transmit_frame_sync_oe,
	// Serial data pins.
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	input  wire logic        serial_data_in,
	// Receive pins, inputs only.
	input  wire logic        receive_serial_clock,
	input  wire logic        receive_frame_sync,
	// Debugger halt request.
	input  wire logic        debug_halt,
	// Ready interrupts.
	output logic             receive_interrupt,
	output logic             transmit_interrupt
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_s1;
	logic [PIN_COUNT-1:0] pin_s2;
	logic [PIN_COUNT-1:0] pin_s3;
	logic [PIN_COUNT-1:0] pin_f;

	assign pin_raw[PIN_TX_CLK]  = transmit_serial_clock_in;
	assign pin_raw[PIN_TX_SYNC] = transmit_frame_sync_in;
	assign pin_raw[PIN_RX_CLK]  = receive_serial_clock;
	assign pin_raw[PIN_RX_SYNC] = receive_frame_sync;
	assign pin_raw[PIN_DATA]    = serial_data_in;

	// A level is accepted only once the second and third stages agree,
	// which rejects a single-cycle glitch at the cost of one cycle.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_f  <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
		end
	end

	// ****************************************************************
	// Control fields
	// ****************************************************************
	logic [15:0] control;
	logic [15:0] tx_data;
	logic [15:0] rx_data;

	wire loopback_select       = control[BIT_LOOPBACK];
	wire word_format_select    = control[BIT_FORMAT];
	wire frame_sync_mode       = control[BIT_FRAME_MODE];
	wire transmit_clock_source = control[BIT_CLOCK_SRC];
	wire transmit_sync_source  = control[BIT_SYNC_SRC];
	wire transmitter_reset_n   = control[BIT_TX_RESET_N];
	wire receiver_reset_n      = control[BIT_RX_RESET_N];
	wire soft_stop             = control[BIT_SOFT_STOP];
	wire free_run              = control[BIT_FREE_RUN];

	// Word length shared by both sections.
	wire [4:0] word_len = word_format_select ? WORD_BITS_BYTE
	                                         : WORD_BITS_FULL;

	// ****************************************************************
	// Register bus slave
	// ****************************************************************
	logic        ack;
	logic        transmit_ready_flag;
	logic        receive_ready_flag;
	logic        underflow_n;
	logic        overrun;
	logic [15:0] ctrl_view;

	// Every access takes one wait cycle; effects land on the edge at
	// which the master sees waitrequest low.
	wire req      = read | write;
	wire go       = req & ack;
	wire sel_ctrl = address == CTRL_OFFSET;
	wire sel_tx   = address == TX_DATA_OFFSET;
	wire sel_rx   = address == RX_DATA_OFFSET;
	wire ctrl_wr  = go & write & sel_ctrl;
	wire tx_wr    = go & write & sel_tx;
	wire rx_rd    = go & read & sel_rx;
	wire rx_gp_wr = go & write & sel_rx & ~receiver_reset_n;

	assign waitrequest = req & ~ack;

	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [15:0] wd,
	                                        input logic [1:0]  be);
		merge16 = {be[1] ? wd[15:8] : old[15:8],
		           be[0] ? wd[7:0]  : old[7:0]};
	endfunction

	// Status bits overlay the stored control bits, which are zero there.
	always_comb begin
		ctrl_view                  = control;
		ctrl_view[BIT_RX_CLK_LVL]  = pin_f[PIN_RX_CLK];
		ctrl_view[BIT_TX_CLK_LVL]  = pin_f[PIN_TX_CLK];
		ctrl_view[BIT_RX_READY]    = receive_ready_flag;
		ctrl_view[BIT_TX_READY]    = transmit_ready_flag;
		ctrl_view[BIT_UNDERFLOW_N] = underflow_n;
		ctrl_view[BIT_OVERRUN]     = overrun;
	end

	wire [15:0] rd_sel = sel_ctrl ? ctrl_view :
	                     sel_tx   ? tx_data   :
	                     sel_rx   ? rx_data   : 16'h0000;

	// Read data is captured in the wait cycle so it is steady at the
	// answering edge.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ack      <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			ack <= req & ~ack;
			if (read && !ack) begin
				readdata <= {16'h0000, rd_sel};
			end
		end
	end

	// Writable control bits; the two-write reconfiguration is simply
	// two ordinary writes here.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			control <= CTRL_RESET;
		end else if (ctrl_wr) begin
			control <= merge16(control, writedata[15:0], byteenable[1:0])
			           & CTRL_WRITE_MASK;
		end
	end

	// ****************************************************************
	// Emulation halt and clock sources
	// ****************************************************************
	tx_state_t        tx_state;
	logic [DIV_W-1:0] div;
	logic             tx_clk_prev;
	logic             fs_out;
	logic             dout;

	wire stop_now = debug_halt & ~free_run & ~soft_stop;
	wire tx_busy  = (tx_state == TX_GEN_SYNC) | (tx_state == TX_ARMED)
	              | (tx_state == TX_SHIFT);
	// Graceful stop keeps the transmit clock only while a word is out.
	wire tx_run   = ~debug_halt | free_run | (soft_stop & tx_busy);
	wire rx_run   = ~stop_now;

	// On-chip transmit clock, a quarter of the block clock.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div <= '0;
		end else begin
			div <= div + {{(DIV_W-1){1'b0}}, tx_run};
		end
	end

	assign transmit_serial_clock_out = div[DIV_W-1];
	assign transmit_serial_clock_oe  = transmit_clock_source
	        & (transmitter_reset_n | receiver_reset_n);

	wire tx_clk_now  = transmit_clock_source ? div[DIV_W-1]
	                                         : pin_f[PIN_TX_CLK];
	wire tx_rise     = tx_clk_now & ~tx_clk_prev & tx_run;
	wire tx_fall     = ~tx_clk_now & tx_clk_prev & tx_run;
	wire tx_sync_now = transmit_sync_source ? fs_out : pin_f[PIN_TX_SYNC];

	// Receive side always listens; loopback swaps in transmit sync and data, and the transmit clock only when it is on-chip.
	wire rx_clk_now  = (loopback_select & transmit_clock_source)
	                   ? tx_clk_now : pin_f[PIN_RX_CLK];
	wire rx_sync_now = loopback_select ? tx_sync_now
	                                   : pin_f[PIN_RX_SYNC];
	wire rx_data_now = loopback_select ? (dout & serial_data_out_oe)
	                                   : pin_f[PIN_DATA];

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	logic [15:0] tx_word;
	logic [15:0] tx_shift;
	logic [4:0]  tx_count;
	logic        tx_have;

	wire [15:0] tx_load = word_format_select ? {tx_data[7:0], 8'h00}
	                                         : tx_data;
	wire tx_last     = (tx_state == TX_SHIFT) & (tx_count == word_len);
	wire tx_copy     = transmitter_reset_n & tx_rise & tx_have
	                 & ((tx_state == TX_IDLE) | tx_last);
	wire tx_continue = tx_copy & tx_last & ~frame_sync_mode;
	wire tx_uflow    = transmitter_reset_n & tx_rise & tx_last & ~tx_have;
	wire ext_sync    = tx_fall & ~transmit_sync_source
	                 & pin_f[PIN_TX_SYNC];
	wire next_transmit_ready_flag   = ~transmitter_reset_n | tx_copy
	                 | (transmit_ready_flag & ~tx_wr);
	wire next_uflow_n = transmitter_reset_n & ~tx_uflow
	                  & (underflow_n | tx_wr);
	wire next_tx_have = tx_wr
	                  | (transmitter_reset_n & tx_have & ~tx_copy);
	wire tx_after_copy_gen = transmit_sync_source;

	// Holding register stays usable as plain storage during reset.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_data <= DATA_RESET;
		end else if (tx_wr) begin
			tx_data <= merge16(tx_data, writedata[15:0], byteenable[1:0]);
		end
	end

	// Ready and underflow flags; a setting event beats a clear.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			transmit_ready_flag               <= TX_READY_RESET;
			underflow_n        <= 1'b0;
			tx_have            <= 1'b0;
			transmit_interrupt <= 1'b0;
			tx_clk_prev        <= 1'b0;
		end else begin
			transmit_ready_flag               <= next_transmit_ready_flag;
			underflow_n        <= next_uflow_n;
			tx_have            <= next_tx_have;
			transmit_interrupt <= next_transmit_ready_flag & ~transmit_ready_flag;
			tx_clk_prev        <= tx_clk_now;
		end
	end

	// Transmit sequencer. Internal sync: copy, sync pulse, then bits on
	// successive rising edges. External sync is sampled on falling
	// edges and is acted on in every state but TX_GEN_SYNC, so a stray pulse restarts
	// the word.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_state <= TX_IDLE;
			tx_word  <= DATA_RESET;
			tx_shift <= DATA_RESET;
			tx_count <= 5'd0;
			fs_out   <= 1'b0;
			dout     <= 1'b0;
		end else if (!transmitter_reset_n || stop_now) begin
			tx_state <= TX_IDLE;
			fs_out   <= 1'b0;
		end else if (ext_sync && tx_state != TX_GEN_SYNC) begin
			tx_state <= TX_ARMED;
		end else if (tx_rise) begin
			unique case (tx_state)
				TX_IDLE, TX_WAIT_SYNC: begin
					if (tx_copy) begin
						tx_word  <= tx_load;
						tx_state <= tx_after_copy_gen ? TX_GEN_SYNC
						                              : TX_WAIT_SYNC;
					end
				end
				TX_GEN_SYNC: begin
					fs_out   <= 1'b1;
					tx_state <= TX_ARMED;
				end
				TX_ARMED: begin
					fs_out   <= 1'b0;
					dout     <= tx_word[15];
					tx_shift <= {tx_word[14:0], 1'b0};
					tx_count <= 5'd1;
					tx_state <= TX_SHIFT;
				end
				TX_SHIFT: begin
					if (!tx_last) begin
						dout     <= tx_shift[15];
						tx_shift <= {tx_shift[14:0], 1'b0};
						tx_count <= 5'(tx_count + 5'd1);
					end else if (tx_continue) begin
						tx_word  <= tx_load;
						dout     <= tx_load[15];
						tx_shift <= {tx_load[14:0], 1'b0};
						tx_count <= 5'd1;
					end else if (tx_copy) begin
						tx_word  <= tx_load;
						tx_state <= tx_after_copy_gen ? TX_GEN_SYNC
						                              : TX_WAIT_SYNC;
					end else begin
						tx_state <= TX_IDLE;
					end
				end
			endcase
		end
	end

	assign transmit_frame_sync_out = fs_out;
	assign transmit_frame_sync_oe  = transmit_sync_source;
	assign serial_data_out         = dout;
	assign serial_data_out_oe      = tx_state == TX_SHIFT;

	// ****************************************************************
	// Receiver
	// ****************************************************************
	rx_state_t   rx_state;
	logic [15:0] rx_shift;
	logic [4:0]  rx_count;
	logic        rsr_full;
	logic        rx_clk_prev;

	wire rx_fall   = ~rx_clk_now & rx_clk_prev & rx_run;
	wire rx_sync_hit = rx_fall & rx_sync_now;
	// Bits are taken only after the sync pulse has ended.
	wire rx_bit    = rx_fall & ~rx_sync_now & (rx_state == RX_SHIFT)
	               & ~overrun;
	wire [15:0] rx_next = {rx_shift[14:0], rx_data_now};
	wire rx_done   = rx_bit & (5'(rx_count + 5'd1) == word_len);
	wire [15:0] rx_word = word_format_select
	                      ? {8'h00, rx_next[7:0]} : rx_next;
	wire [15:0] rx_held = word_format_select
	                      ? {8'h00, rx_shift[7:0]} : rx_shift;
	wire rx_copy_new = rx_done & (~receive_ready_flag | rx_rd);
	wire rx_copy_old = rx_rd & rsr_full;
	wire rx_full_evt = rx_done & receive_ready_flag & ~rx_rd;
	wire rx_ovr_evt  = (rx_full_evt & ~frame_sync_mode)
	                 | (rx_sync_hit & frame_sync_mode & rsr_full);
	wire next_receive_ready_flag   = receiver_reset_n
	        & (rx_copy_new | rx_copy_old | (receive_ready_flag & ~rx_rd));
	wire next_overrun = receiver_reset_n
	        & (rx_ovr_evt | (overrun & ~rx_rd));
	wire next_rsr_full = receiver_reset_n
	        & (rx_full_evt | (rsr_full & ~rx_rd));
	wire rx_start  = rx_sync_hit & ~overrun
	               & ~(frame_sync_mode & rsr_full);

	// Ready, overrun and holding register; a read that meets a held
	// word moves it across so nothing is lost.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			receive_ready_flag              <= 1'b0;
			overrun           <= 1'b0;
			rsr_full          <= 1'b0;
			rx_data           <= DATA_RESET;
			receive_interrupt <= 1'b0;
			rx_clk_prev       <= 1'b0;
		end else begin
			receive_ready_flag              <= next_receive_ready_flag;
			overrun           <= next_overrun;
			rsr_full          <= next_rsr_full;
			receive_interrupt <= next_receive_ready_flag & ~receive_ready_flag;
			rx_clk_prev       <= rx_clk_now;
			if (rx_copy_new) begin
				rx_data <= rx_word;
			end else if (rx_copy_old) begin
				rx_data <= rx_held;
			end else if (rx_gp_wr) begin
				rx_data <= merge16(rx_data, writedata[15:0],
				                   byteenable[1:0]);
			end
		end
	end

	// Receive sequencer. Burst mode drops back to idle after each word;
	// continuous mode keeps shifting after the first sync.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_state <= RX_IDLE;
			rx_shift <= DATA_RESET;
			rx_count <= 5'd0;
		end else if (!receiver_reset_n || stop_now) begin
			rx_state <= RX_IDLE;
			rx_count <= 5'd0;
		end else if (rx_start) begin
			rx_state <= RX_SHIFT;
			rx_count <= 5'd0;
		end else if (rx_bit) begin
			rx_shift <= rx_next;
			rx_count <= rx_done ? 5'd0 : 5'(rx_count + 5'd1);
			if (rx_done && frame_sync_mode) begin
				rx_state <= RX_IDLE;
			end
		end
	end

endmodule

`default_nettype wire

// *** dv/serial_peer.sv ***
`timescale 1ns/1ps
`default_nettype none

module serial_peer (
	// Framed link lines toward the port.
	output var logic sclk,
	output var logic fsync,
	output var logic sdata
);
	// *************************************************************
	// Peer codec: idles with a still clock, sends on demand.
	// *************************************************************
	initial begin
		sclk  = 1'b0;
		fsync = 1'b0;
		sdata = 1'b0;
	end

	// Parks the idle clock at a level, so it can serve as a bit input.
	task automatic level(input logic l);
		sclk <= l;
	endtask

	// One framed word, MSB first, 400 ns link period, any phase.
	// A sync pulse opens every word, so burst and continuous both work.
	task automatic send(input logic [15:0] w, input int n);
		#37;
		sclk  = 1'b1;
		fsync = 1'b1;
		#200 sclk = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#200 sclk = 1'b1;
			fsync = 1'b0;
			sdata = w[i];
			#200 sclk = 1'b0;
		end
		// A released line must not keep its last value.
		#200 sdata = ~sdata;
	endtask
endmodule

`default_nettype wire

// *** dv/framed_serial_port_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module framed_serial_port_chk
	import framed_serial_pkg::*;
(
	// Clock, reset and bus.
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic        waitrequest,
	// Pins, halt and interrupts.
	input  wire logic        transmit_serial_clock_out,
	input  wire logic        transmit_serial_clock_oe,
	input  wire logic        transmit_frame_sync_out,
	input  wire logic        transmit_frame_sync_oe,
	input  wire logic        serial_data_out_oe,
	input  wire logic        debug_halt,
	input  wire logic        receive_interrupt,
	input  wire logic        transmit_interrupt
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	logic [15:0] ctrl;
	logic [7:0]  cnt;

	// *************************************************************
	// Control shadow and a count of cycles with data driven.
	// *************************************************************
	// Byte lanes are ignored, so only whole-word writes keep it true.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= CTRL_RESET;
			cnt  <= 8'h00;
		end else begin
			if (write && !waitrequest && address == CTRL_OFFSET)
				ctrl <= writedata[15:0] & CTRL_WRITE_MASK;
			cnt <= serial_data_out_oe ? cnt + 8'h01 : 8'h00;
		end
	end

	// *************************************************************
	// Properties.
	// *************************************************************
	AST_BUS_WAIT: assert property (
		$rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus answer timing off");
	AST_SYNC_OE: assert property (
		transmit_frame_sync_oe == ctrl[BIT_SYNC_SRC])
		else $error("sync pin direction wrong");
	AST_CLK_OE: assert property (
		transmit_serial_clock_oe == (ctrl[BIT_CLOCK_SRC] &&
		(ctrl[BIT_TX_RESET_N] || ctrl[BIT_RX_RESET_N])))
		else $error("clock pin direction wrong");
	AST_CLK_RATE: assert property (
		(transmit_serial_clock_oe &&
		(!debug_halt || ctrl[BIT_FREE_RUN]))[*3] |->
		transmit_serial_clock_out != $past(transmit_serial_clock_out, 2))
		else $error("clock not a quarter rate");
	AST_HALT: assert property (
		debug_halt && $past(debug_halt) && $past(debug_halt, 2) &&
		ctrl[15:14] == 2'h0 |-> $stable(transmit_serial_clock_out))
		else $error("clock runs during halt");
	AST_SYNC_WIDTH: assert property (
		$rose(transmit_frame_sync_out) && ctrl[BIT_CLOCK_SRC] &&
		ctrl[BIT_SYNC_SRC] && !debug_halt |->
		transmit_frame_sync_out[*4] ##1 !transmit_frame_sync_out)
		else $error("sync pulse width wrong");
	AST_SYNC_DATA: assert property (
		$fell(transmit_frame_sync_out) && transmit_frame_sync_oe |->
		serial_data_out_oe)
		else $error("no data after sync");
	AST_WORD_LEN: assert property (
		$fell(serial_data_out_oe) && ctrl[BIT_CLOCK_SRC] |->
		cnt % (ctrl[BIT_FORMAT] ? 8'h20 : 8'h40) == 8'h00)
		else $error("word length wrong");
	AST_TX_SYNC: assert property (
		transmit_interrupt && ctrl[BIT_SYNC_SRC] && ctrl[BIT_TX_RESET_N]
		|-> ##[1:12] transmit_frame_sync_out)
		else $error("no sync after load");
	AST_RX_INT: assert property (
		receive_interrupt |=> !receive_interrupt)
		else $error("receive interrupt too long");

	// Main scenarios reached.
	cover property ($fell(serial_data_out_oe));
	cover property (receive_interrupt);
	cover property (debug_halt && transmit_serial_clock_oe);
endmodule

bind framed_serial_port framed_serial_port_chk i_chk (
	.mclk, .rstn, .address, .read, .write, .writedata, .waitrequest,
	.transmit_serial_clock_out, .transmit_serial_clock_oe,
	.transmit_frame_sync_out, .transmit_frame_sync_oe,
	.serial_data_out_oe, .debug_halt, .receive_interrupt,
	.transmit_interrupt
);

`default_nettype wire

// *** dv/framed_serial_port_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module framed_serial_port_control_test;
	import framed_serial_pkg::*;

	logic        mclk;
	logic        rstn;
	logic        read;
	logic        write;
	logic        dbg;
	logic [3:0]  address;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        tclk_out;
	logic        tclk_oe;
	logic        tsync_out;
	logic        tsync_oe;
	logic        pclk;
	logic        psync;
	logic        pdata;
	logic [15:0] q;
	int          err_count;
	int          comparisons;

	// Pin levels; the peer's sync reaches the sync pin when it is an input.
	wire logic tclk_pin = tclk_oe ? tclk_out : pclk;
	wire logic tsync_pin = tsync_oe ? tsync_out : psync;

	// The receive pins are fed by the peer only.
	framed_serial_port i_dut (
		.mclk, .rstn, .address, .read, .write, .writedata,
		.byteenable(4'hf), .readdata, .waitrequest,
		.transmit_serial_clock_in(tclk_pin),
		.transmit_serial_clock_out(tclk_out),
		.transmit_serial_clock_oe(tclk_oe),
		.transmit_frame_sync_in(tsync_pin),
		.transmit_frame_sync_out(tsync_out),
		.transmit_frame_sync_oe(tsync_oe),
		.serial_data_out(), .serial_data_out_oe(),
		.serial_data_in(pdata), .receive_serial_clock(pclk),
		.receive_frame_sync(psync), .debug_halt(dbg),
		.receive_interrupt(), .transmit_interrupt()
	);
	serial_peer i_peer (.sclk(pclk), .fsync(psync), .sdata(pdata));

	// Block clock.
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// *************************************************************
	// Tasks.
	// *************************************************************
	task automatic summarize();
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp,
			input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One transfer; request held until waitrequest is seen low.
	task automatic bus(input logic we, input logic [3:0] a,
			input logic [15:0] d);
		int n;
		n = 0;
		address   <= a;
		writedata <= {16'h0000, d};
		read      <= !we;
		write     <= we;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata[15:0];
		read  <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			err_count++;
			summarize();
		end
		@(posedge mclk);
	endtask

	// Two writes: sections held in reset, then released.
	task automatic cfg(input logic [15:0] d);
		bus(1'b1, CTRL_OFFSET, d & 16'hff3f);
		bus(1'b1, CTRL_OFFSET, d);
	endtask

	// Polls a status bit under a bounded count of reads.
	task automatic poll(input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, CTRL_OFFSET, 16'h0000);
			n++;
		end while (q[b] !== 1'b1 && n < 200);
		if (q[b] !== 1'b1) begin
			err_count++;
			summarize();
		end
	endtask

	// *************************************************************
	// Sequence.
	// *************************************************************
	initial begin
		err_count   = 0;
		comparisons = 0;
		rstn        = 1'b0;
		read        = 1'b0;
		write       = 1'b0;
		dbg         = 1'b0;
		address     = 4'h0;
		writedata   = 32'h0000_0000;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		// A word sent while the receiver is still in reset is not taken.
		i_peer.send(16'hbeef, 16);
		@(posedge mclk);
		bus(1'b0, CTRL_OFFSET, 16'h0000);
		chk("control after reset", 16'h0800, q);
		bus(1'b0, 4'hc, 16'h0000);
		chk("unmapped read", 16'h0000, q);
		for (int l = 0; l < 2; l++) begin
			i_peer.level(l[0]);
			repeat (4) @(posedge mclk);
			bus(1'b0, CTRL_OFFSET, 16'h0000);
			chk("pin levels", {14'h0, l[0], l[0]}, {14'h0, q[9:8]});
		end
		i_peer.level(1'b0);
		// Loopback with on-chip clock and sync, burst, word then byte.
		cfg(16'h00fa);
		bus(1'b1, TX_DATA_OFFSET, 16'ha5c3);
		poll(BIT_RX_READY);
		repeat (20) @(posedge mclk);
		bus(1'b0, CTRL_OFFSET, 16'h0000);
		chk("status after word", 16'h0cfa, q & 16'hfcff);
		bus(1'b0, RX_DATA_OFFSET, 16'h0000);
		chk("looped word", 16'ha5c3, q);
		cfg(16'h00fe);
		bus(1'b1, TX_DATA_OFFSET, 16'h12ab);
		poll(BIT_RX_READY);
		bus(1'b0, RX_DATA_OFFSET, 16'h0000);
		chk("looped byte", 16'h00ab, q & 16'h00ff);
		// Halt with both emulation bits low freezes the clock.
		dbg <= 1'b1;
		repeat (20) @(posedge mclk);
		dbg <= 1'b0;
		// Free-run keeps the clock going through a halt.
		cfg(16'h80fe);
		dbg <= 1'b1;
		repeat (20) @(posedge mclk);
		dbg <= 1'b0;
		// Loopback on the outside clock; the peer supplies the sync.
		cfg(16'h00ca);
		bus(1'b1, TX_DATA_OFFSET, 16'h5a3c);
		i_peer.send(16'h0000, 16);
		@(posedge mclk);
		poll(BIT_RX_READY);
		bus(1'b0, RX_DATA_OFFSET, 16'h0000);
		chk("external sync word", 16'h5a3c, q);
		// Outside clock, continuous receive, two words left unread.
		cfg(16'h0080);
		i_peer.send(16'h1234, 16);
		i_peer.send(16'h5678, 16);
		@(posedge mclk);
		bus(1'b0, CTRL_OFFSET, 16'h0000);
		chk("overrun set", 16'h2400, q & 16'h3400);
		bus(1'b0, RX_DATA_OFFSET, 16'h0000);
		chk("held word", 16'h1234, q);
		repeat (4) @(posedge mclk);
		bus(1'b0, CTRL_OFFSET, 16'h0000);
		chk("overrun cleared", 16'h0400, q & 16'h3400);
		bus(1'b0, RX_DATA_OFFSET, 16'h0000);
		chk("shifter word", 16'h5678, q);
		summarize();
	end
endmodule

`default_nettype wire
